// ### verilog/nfc_field_cmd.v
// Direct command interpreter: transmit, field-on, normal mode, analog preset
`timescale 1ns/1ps
`include "nfc_field_cmd_defines.vh"

// Function
// - Transmit commands only while transmitter enabled
// - Request-A and wake-up-A need no clear
// - Next command may follow a transmit immediately
// - No completion event for transmit commands
// - No outside field: field on, guard, done
// - Outside field: collision flag, field stays off
// - Initial: 4096 plus n times 512, guard 5ms
// - Response: 768 plus n times 512, guard 1024
// - Response variant forces slot count zero
// - Active delay sits at lower limit
// - Field-on needs global enable, stable oscillator
// - Go-normal leaves rate detection for normal mode
// - Go-normal copies detected rate, sets modulation type
// - Analog preset loads settings from mode, rate
// - Active preset: one channel, transmitter off
// - Target or active initiator preset: transmitter off
// - Active preset sets start-byte and length insert
// - Clear stops activity, FIFO, timers, flags
module nfc_field_cmd
#(
   parameter [31:0] INITIAL_DELAY_CYC = (`INITIAL_DELAY_PERIOD_FC *
      `CLK_10KHZ + `FC_10KHZ - 32'd1) / `FC_10KHZ,
   parameter [31:0] RF_WAITING_CYC = (`RF_WAITING_PERIOD_FC *
      `CLK_10KHZ + `FC_10KHZ - 32'd1) / `FC_10KHZ,
   parameter [31:0] INITIAL_GUARD_CYC = `INITIAL_GUARD_PERIOD_MS *
      `CLK_10KHZ * 32'd10 + 32'd1,
   parameter [31:0] ACTIVE_DELAY_CYC = (`ACTIVE_DELAY_PERIOD_FC *
      `CLK_10KHZ + `FC_10KHZ - 32'd1) / `FC_10KHZ,
   parameter [31:0] ACTIVE_GUARD_CYC = (`ACTIVE_GUARD_PERIOD_FC *
      `CLK_10KHZ + `FC_10KHZ - 32'd1) / `FC_10KHZ
)
(
   input wire ref_clk,
   input wire rstn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire ext_field_pin,
   input wire osc_freq_ok_pin,
   input wire osc_ampl_ok_pin,
   input wire [7:0] rate_detect_display,
   output reg tx_start,
   output reg [1:0] tx_kind,
   output reg activity_clear,
   output wire field_on,
   output wire [7:0] operation_control_out,
   output wire [7:0] type_a_settings_out,
   output wire [7:0] aux_definition_out,
   output wire [7:0] rx_config_1_out,
   output wire [7:0] rx_config_3_out
);

////////////////////////////////////////////////////////////////////////////
// Field-on sequencer states
localparam [1:0] F_IDLE = 2'd0;
localparam [1:0] F_DELAY = 2'd1;
localparam [1:0] F_GUARD = 2'd2;

reg [7:0] operation_control; // Global enable, rx channel, tx enable
reg [7:0] mode_definition; // Mode field in bits 7:3
reg [7:0] bit_rate_definition; // Transmit rate in bits 1:0
reg [7:0] type_a_106k_settings; // Start-byte option
reg [7:0] auxiliary_definition; // Slot count, modulation, detector
reg [7:0] rx_config_1; // Receive channel select
reg [7:0] rx_config_3; // Limiter and gain reduction
reg [1:0] events; // Sticky done and collision flags
reg [1:0] fstate; // Sequencer state
reg [31:0] fcount; // Cycles left in current phase
reg initial_seq; // Initial rather than response sequence
reg done_set; // One-cycle set for done flag
reg coll_set; // One-cycle set for collision flag
reg [2:0] pin_meta; // First synchroniser stage
reg [2:0] pin_sync; // Second synchroniser stage
reg wr_pend; // Write data phase pending
reg [7:0] wr_idx; // Register index of pending write

wire ext_field = pin_sync[0];
wire osc_freq_ok = pin_sync[1];
wire osc_ampl_ok = pin_sync[2];
wire [4:0] mode = mode_definition[7:3];
wire busy = (fstate != F_IDLE);
wire [1:0] slot_n = {auxiliary_definition[`AUX_SLOT_COUNT_HIGH],
   auxiliary_definition[`AUX_SLOT_COUNT_LOW]};
wire [31:0] slot_wait = {30'd0, slot_n} * RF_WAITING_CYC;
wire active_p2p = (mode == `MODE_ACTIVE_INITIATOR) ||
   (mode == `MODE_TARGET_ACTIVE) || (mode == `MODE_TARGET_RATE_DETECT);
wire stream_mode = (mode == `MODE_SUBCARRIER_STREAM) ||
   (mode == `MODE_BPSK_STREAM);

// Address phase and command write decode
wire addr_phase = hsel && hready && htrans[1];
wire [7:0] addr_idx = (haddr[31:10] == 22'd0) ? haddr[9:2] : 8'hff;
wire cmd_fire = wr_pend && (wr_idx == `IDX_COMMAND);
wire [7:0] cmd = hwdata[7:0];
wire en_ok = operation_control[`OPC_GLOBAL_EN];
wire tx_ok = operation_control[`OPC_TX_EN];
wire clear_ok = en_ok && osc_freq_ok;
wire field_ok = en_ok && osc_freq_ok && osc_ampl_ok && !busy;
wire evt_wr = wr_pend && (wr_idx == `IDX_EVENTS);

// Zero wait state slave, always OKAY
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign field_on = operation_control[`OPC_TX_EN];
assign operation_control_out = operation_control;
assign type_a_settings_out = type_a_106k_settings;
assign aux_definition_out = auxiliary_definition;
assign rx_config_1_out = rx_config_1;
assign rx_config_3_out = rx_config_3;

////////////////////////////////////////////////////////////////////////////
// Two-stage synchronisers for pins from the analog side
always @(posedge ref_clk or negedge rstn)
begin
   if (!rstn)
   begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
   end
   else
   begin
      pin_meta <= {osc_ampl_ok_pin, osc_freq_ok_pin, ext_field_pin};
      pin_sync <= pin_meta;
   end
end

////////////////////////////////////////////////////////////////////////////
// Bus address phase capture and read data
// Read data is registered; a write in the data phase just before is forwarded, except to command,
// status, events and rate display, so back-to-back write then read sees the new byte.
always @(posedge ref_clk or negedge rstn)
begin
   if (!rstn)
   begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
      hrdata <= 32'h0;
   end
   else
   begin
      wr_pend <= addr_phase && hwrite;
      if (addr_phase)
         wr_idx <= addr_idx;
      if (addr_phase && !hwrite)
      begin
         if (wr_pend && wr_idx == addr_idx && addr_idx != `IDX_EVENTS &&
            addr_idx != `IDX_COMMAND && addr_idx != `IDX_STATUS &&
            addr_idx != `IDX_RATE_DETECT_DISPLAY)
            // Forward pending write
            hrdata <= {24'h0, hwdata[7:0]};
         else
            hrdata <= {24'h0, read_mux(addr_idx)};
      end
   end
end

// Register read selection; unmapped and write-only read zero
function [7:0] read_mux;
   input [7:0] idx;
   begin
      case (idx)
         `IDX_OPERATION_CONTROL: read_mux = operation_control;
         `IDX_MODE_DEFINITION: read_mux = mode_definition;
         `IDX_BIT_RATE_DEFINITION: read_mux = bit_rate_definition;
         `IDX_TYPE_A_106K_SETTINGS: read_mux = type_a_106k_settings;
         `IDX_AUXILIARY_DEFINITION: read_mux = auxiliary_definition;
         `IDX_RECEIVER_CONFIG_1: read_mux = rx_config_1;
         `IDX_RECEIVER_CONFIG_3: read_mux = rx_config_3;
         `IDX_STATUS: read_mux = {4'h0, ext_field, osc_ampl_ok,
            osc_freq_ok, busy};
         `IDX_EVENTS: read_mux = {6'h0, events};
         `IDX_RATE_DETECT_DISPLAY: read_mux = rate_detect_display;
         default: read_mux = 8'h00;
      endcase
   end
endfunction

////////////////////////////////////////////////////////////////////////////
// Sticky event flags; a set in the clearing cycle wins
always @(posedge ref_clk or negedge rstn)
begin
   if (!rstn)
      events <= 2'b00;
   else
   begin
      // Clear command or write-one-to-clear, then hardware sets
      if (cmd_fire && cmd == `CMD_CLEAR && clear_ok)
         events <= {coll_set, done_set};
      else if (evt_wr)
         events <= (events & ~hwdata[1:0]) | {coll_set, done_set};
      else
         events <= events | {coll_set, done_set};
   end
end

////////////////////////////////////////////////////////////////////////////
// Registers, command execution and field-on sequencer
// One process owns every register a command may touch except the event
// flags, so bus writes and command effects never fight; later statements take priority.
always @(posedge ref_clk or negedge rstn)
begin
   if (!rstn)
   begin
      operation_control <= `RST_OPERATION_CONTROL;
      mode_definition <= `RST_MODE_DEFINITION;
      bit_rate_definition <= `RST_BIT_RATE_DEFINITION;
      type_a_106k_settings <= `RST_TYPE_A_106K_SETTINGS;
      auxiliary_definition <= `RST_AUXILIARY_DEFINITION;
      rx_config_1 <= `RST_RECEIVER_CONFIG_1;
      rx_config_3 <= `RST_RECEIVER_CONFIG_3;
      fstate <= F_IDLE;
      fcount <= 32'h0;
      initial_seq <= 1'b0;
      done_set <= 1'b0;
      coll_set <= 1'b0;
      tx_start <= 1'b0;
      tx_kind <= `TXK_WITH_CHECKSUM;
      activity_clear <= 1'b0;
   end
   else
   begin
      // Pulses default low
      done_set <= 1'b0;
      coll_set <= 1'b0;
      tx_start <= 1'b0;
      activity_clear <= 1'b0;

      // Plain register writes
      if (wr_pend)
      begin
         case (wr_idx)
            `IDX_OPERATION_CONTROL: operation_control <= hwdata[7:0];
            `IDX_MODE_DEFINITION: mode_definition <= hwdata[7:0];
            `IDX_BIT_RATE_DEFINITION: bit_rate_definition <= hwdata[7:0];
            `IDX_TYPE_A_106K_SETTINGS: type_a_106k_settings <= hwdata[7:0];
            `IDX_AUXILIARY_DEFINITION: auxiliary_definition <= hwdata[7:0];
            `IDX_RECEIVER_CONFIG_1: rx_config_1 <= hwdata[7:0];
            `IDX_RECEIVER_CONFIG_3: rx_config_3 <= hwdata[7:0];
            default: ; // Events, read-only, command or unmapped
         endcase
      end

      // Field-on sequencer
      case (fstate)
         F_IDLE: ;
         F_DELAY:
         begin
            if (ext_field)
            begin
               // Someone else radiates: report, keep own field off
               coll_set <= 1'b1;
               fstate <= F_IDLE;
            end
            else if (fcount <= 32'd1)
            begin
               // Quiet for the whole delay: switch on and guard
               operation_control[`OPC_TX_EN] <= 1'b1;
               fcount <= initial_seq ? INITIAL_GUARD_CYC :
                  ACTIVE_GUARD_CYC;
               fstate <= F_GUARD;
            end
            else
               fcount <= fcount - 32'd1;
         end
         F_GUARD:
         begin
            if (fcount <= 32'd1)
            begin
               done_set <= 1'b1;
               fstate <= F_IDLE;
            end
            else
               fcount <= fcount - 32'd1;
         end
         default: fstate <= F_IDLE;
      endcase

      // Command execution; refused commands fall through untouched
      if (cmd_fire)
      begin
         case (cmd)
            `CMD_CLEAR:
            begin
               if (clear_ok)
               begin
                  // Aborts any field-on sequence as well
                  activity_clear <= 1'b1;
                  fstate <= F_IDLE;
                  fcount <= 32'h0;
               end
            end
            `CMD_TX_WITH_CHECKSUM, `CMD_TX_WITHOUT_CHECKSUM,
            `CMD_TX_REQUEST_A, `CMD_TX_WAKEUP_A:
            begin
               // No busy state and no event: next command may follow
               if (tx_ok)
               begin
                  tx_start <= 1'b1;
                  tx_kind <= cmd[1:0];
               end
            end
            `CMD_INITIAL_FIELD_ON:
            begin
               if (field_ok)
               begin
                  initial_seq <= 1'b1;
                  fcount <= INITIAL_DELAY_CYC + slot_wait;
                  fstate <= F_DELAY;
               end
            end
            `CMD_RESPONSE_FIELD_ON, `CMD_RESPONSE_FIELD_ON_N0:
            begin
               if (field_ok)
               begin
                  initial_seq <= 1'b0;
                  // Shortest legal active delay; host latency fills rest
                  if (cmd == `CMD_RESPONSE_FIELD_ON_N0)
                     fcount <= ACTIVE_DELAY_CYC;
                  else
                     fcount <= ACTIVE_DELAY_CYC + slot_wait;
                  fstate <= F_DELAY;
               end
            end
            `CMD_GO_NORMAL_MODE:
            begin
               if (en_ok && mode == `MODE_TARGET_RATE_DETECT)
               begin
                  mode_definition <= {`MODE_TARGET_ACTIVE,
                     mode_definition[2:0]};
                  bit_rate_definition <= rate_detect_display;
                  // Only the lowest rate uses on-off keying
                  auxiliary_definition[`AUX_MODULATION_TYPE_SELECT] <=
                     (rate_detect_display[1:0] != 2'h0);
               end
            end
            `CMD_ANALOG_PRESET:
            begin
               // Stream modes left alone; host must not ask there
               if (en_ok && !stream_mode)
               begin
                  auxiliary_definition[`AUX_MODULATION_TYPE_SELECT] <=
                     (mode == `MODE_ISO_B) ||
                     (bit_rate_definition[1:0] != 2'h0);
                  auxiliary_definition[`AUX_FIELD_DETECT_EN] <= active_p2p;
                  rx_config_1[`RXC1_CHANNEL_SELECT] <= !active_p2p;
                  rx_config_3[`RXC3_LIMITER] <= active_p2p;
                  rx_config_3[`RXC3_GAIN_REDUCE] <= active_p2p;
                  type_a_106k_settings[`TYPEA_START_BYTE_LENGTH_INSERT] <=
                     active_p2p;
                  if (active_p2p)
                     operation_control[`OPC_RX_ONE_CHANNEL] <=
                        1'b1;
                  if (active_p2p || mode[4])
                     operation_control[`OPC_TX_EN] <=
                        1'b0;
               end
            end
            default: ; // Unknown codes ignored
         endcase
      end
   end
end

endmodule

// ### verilog/nfc_field_cmd_defines.vh
// Register map, field layout, command codes and timing for the command block
`ifndef NFC_FIELD_CMD_DEFINES_VH
`define NFC_FIELD_CMD_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_COMMAND 8'h01
`define IDX_OPERATION_CONTROL 8'h02
`define IDX_MODE_DEFINITION 8'h03
`define IDX_BIT_RATE_DEFINITION 8'h04
`define IDX_TYPE_A_106K_SETTINGS 8'h05
`define IDX_AUXILIARY_DEFINITION 8'h09
`define IDX_RECEIVER_CONFIG_1 8'h0a
`define IDX_RECEIVER_CONFIG_3 8'h0c
`define IDX_STATUS 8'h1a
`define IDX_EVENTS 8'h1b
`define IDX_RATE_DETECT_DISPLAY 8'h1c

// Reset values
`define RST_OPERATION_CONTROL 8'h00
`define RST_MODE_DEFINITION 8'h08
`define RST_BIT_RATE_DEFINITION 8'h00
`define RST_TYPE_A_106K_SETTINGS 8'h00
`define RST_AUXILIARY_DEFINITION 8'h00
`define RST_RECEIVER_CONFIG_1 8'h00
`define RST_RECEIVER_CONFIG_3 8'h00

// Bit positions
`define OPC_GLOBAL_EN 7
`define OPC_RX_ONE_CHANNEL 5
`define OPC_TX_EN 3
`define TYPEA_START_BYTE_LENGTH_INSERT 5
`define AUX_SLOT_COUNT_HIGH 7
`define AUX_SLOT_COUNT_LOW 6
`define AUX_MODULATION_TYPE_SELECT 5
`define AUX_FIELD_DETECT_EN 4
`define RXC1_CHANNEL_SELECT 7
`define RXC3_LIMITER 1
`define RXC3_GAIN_REDUCE 0
`define EVT_FIELD_ON_DONE 0
`define EVT_COLLISION 1

// Mode field is mode_definition[7:3]; its top bit marks a target mode
`define MODE_ISO_A 5'h01
`define MODE_ISO_B 5'h02
`define MODE_ACTIVE_INITIATOR 5'h03
`define MODE_SUBCARRIER_STREAM 5'h0e
`define MODE_BPSK_STREAM 5'h0f
`define MODE_TARGET_RATE_DETECT 5'h10
`define MODE_TARGET_ACTIVE 5'h11

// Command codes
`define CMD_CLEAR 8'hc2
`define CMD_TX_WITH_CHECKSUM 8'hc4
`define CMD_TX_WITHOUT_CHECKSUM 8'hc5
`define CMD_TX_REQUEST_A 8'hc6
`define CMD_TX_WAKEUP_A 8'hc7
`define CMD_INITIAL_FIELD_ON 8'hc8
`define CMD_RESPONSE_FIELD_ON 8'hc9
`define CMD_RESPONSE_FIELD_ON_N0 8'hca
`define CMD_GO_NORMAL_MODE 8'hcb
`define CMD_ANALOG_PRESET 8'hcc

// Transmit kinds on tx_kind
`define TXK_WITH_CHECKSUM 2'h0
`define TXK_WITHOUT_CHECKSUM 2'h1
`define TXK_REQUEST_A 2'h2
`define TXK_WAKEUP_A 2'h3

// Rates in units of 10 kHz keep every product inside 32 bits
`define CLK_10KHZ 32'd10000
`define FC_10KHZ 32'd1356
`define INITIAL_DELAY_PERIOD_FC 32'd4096
`define RF_WAITING_PERIOD_FC 32'd512
`define INITIAL_GUARD_PERIOD_MS 32'd5
`define ACTIVE_DELAY_PERIOD_FC 32'd768
`define ACTIVE_GUARD_PERIOD_FC 32'd1024

`endif

// ### verification/nfc_field_cmd_props.sv
// Port-level assertions for the direct command block
`timescale 1ns/1ps
module nfc_field_cmd_props
(
   input wire ref_clk,
   input wire rstn,
   input wire hreadyout,
   input wire hresp,
   input wire ext_field_pin,
   input wire tx_start,
   input wire [1:0] tx_kind,
   input wire activity_clear,
   input wire field_on,
   input wire [7:0] operation_control_out,
   input wire [7:0] type_a_settings_out,
   input wire [7:0] aux_definition_out,
   input wire [7:0] rx_config_1_out,
   input wire [7:0] rx_config_3_out
);
   // One clock domain, so one default clock and reset
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////
   AST_BUS_ZERO_WAIT: assert property (hreadyout && !hresp)
      else $error("bus answer is not zero-wait OKAY");
   AST_TX_NEEDS_EN: assert property (
      tx_start |-> $past(operation_control_out[3]) ##1 !tx_start)
      else $error("transmit pulse without transmitter enable");
   AST_KIND_HELD: assert property (!tx_start |-> $stable(tx_kind))
      else $error("transmit kind moved without a transmit");
   AST_CLEAR_PULSE: assert property (
      activity_clear |-> $past(operation_control_out[7]) ##1 !activity_clear)
      else $error("clear pulse without global enable");
   AST_FIELD_MIRROR: assert property (
      field_on == operation_control_out[3])
      else $error("field output differs from transmitter enable");
   // Synchroniser delay is covered by the eight-cycle run-up
   AST_NO_FIELD_UNDER_EXT: assert property (
      ext_field_pin [*8] |-> !$rose(field_on))
      else $error("field switched on under an outside field");
   AST_PRESET_ACTIVE: assert property (
      $rose(type_a_settings_out[5]) |-> operation_control_out[5]
      && !operation_control_out[3] && rx_config_3_out[1:0] == 2'b11)
      else $error("active preset left channel or transmitter wrong");
   AST_PRESET_TX_OFF: assert property (
      $rose(operation_control_out[5]) |-> !field_on)
      else $error("preset left the field on");
   AST_PRESET_RX: assert property (
      $rose(rx_config_3_out[1]) |-> aux_definition_out[4]
      && !rx_config_1_out[7])
      else $error("preset receiver bits inconsistent");
endmodule
bind nfc_field_cmd nfc_field_cmd_props nfc_field_cmd_props_i (
   .ref_clk(ref_clk), .rstn(rstn), .hreadyout(hreadyout), .hresp(hresp),
   .ext_field_pin(ext_field_pin), .tx_start(tx_start), .tx_kind(tx_kind),
   .activity_clear(activity_clear), .field_on(field_on),
   .operation_control_out(operation_control_out),
   .type_a_settings_out(type_a_settings_out),
   .aux_definition_out(aux_definition_out),
   .rx_config_1_out(rx_config_1_out), .rx_config_3_out(rx_config_3_out));

// ### verification/host_bus_master.sv
// Host model: single-word AHB-Lite master for registers and commands
`timescale 1ns/1ps
module host_bus_master
(
   input wire ref_clk,
   input wire hready,
   input wire [31:0] hrdata,
   output reg hsel,
   output reg [31:0] haddr,
   output reg [1:0] htrans,
   output reg hwrite,
   output reg [2:0] hsize,
   output reg [31:0] hwdata
);
   // Idle bus from time zero
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   // One transfer; caller enters just after a rising edge
   task xfer(input wr, input [31:0] a, input [31:0] d, output [31:0] q);
   begin
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      @(posedge ref_clk);
      while (hready !== 1'b1)
         @(posedge ref_clk);
      // Released lines show the inverse so stale values are not trusted
      hsel <= 1'b0;
      haddr <= ~a;
      htrans <= 2'b00;
      hwdata <= wr ? d : ~d;
      @(posedge ref_clk);
      while (hready !== 1'b1)
         @(posedge ref_clk);
      q = hrdata;
   end
   endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the direct command block
`timescale 1ns/1ps
`include "nfc_field_cmd_defines.vh"
module tb_top;
   reg ref_clk;
   reg rstn;
   reg ext_field_pin;
   reg osc_freq_ok_pin;
   reg osc_ampl_ok_pin;
   reg [7:0] rate_detect_display;
   wire hsel;
   wire [31:0] haddr;
   wire [1:0] htrans;
   wire hwrite;
   wire [2:0] hsize;
   wire [31:0] hwdata;
   wire hreadyout;
   wire hresp;
   wire [31:0] hrdata;
   wire tx_start;
   wire [1:0] tx_kind;
   wire activity_clear;
   wire field_on;
   wire [7:0] opc;
   wire [7:0] tas;
   wire [7:0] aux;
   wire [7:0] rc1;
   wire [7:0] rc3;
   integer errors;
   integer n_tests;
   integer n_tx;
   integer n_clr;
   reg [7:0] kind_log; // Last four transmit kinds, newest lowest
   reg [31:0] q;
   // Short counts keep the 5 ms guard affordable in simulation
   nfc_field_cmd #(.INITIAL_DELAY_CYC(32'd20), .RF_WAITING_CYC(32'd8),
      .INITIAL_GUARD_CYC(32'd40), .ACTIVE_DELAY_CYC(32'd10),
      .ACTIVE_GUARD_CYC(32'd12)) nfc_field_cmd_i (.ref_clk(ref_clk),
      .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .ext_field_pin(ext_field_pin), .osc_freq_ok_pin(osc_freq_ok_pin),
      .osc_ampl_ok_pin(osc_ampl_ok_pin),
      .rate_detect_display(rate_detect_display), .tx_start(tx_start),
      .tx_kind(tx_kind), .activity_clear(activity_clear),
      .field_on(field_on), .operation_control_out(opc),
      .type_a_settings_out(tas), .aux_definition_out(aux),
      .rx_config_1_out(rc1), .rx_config_3_out(rc3));
   host_bus_master host_bus_master_i (.ref_clk(ref_clk),
      .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   ////////////////////////////////////////////////////////////////////////
   // 100 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever
         #5 ref_clk = ~ref_clk;
   end
   // Counts pulses seen at the command outputs
   always @(posedge ref_clk)
   begin
      if (tx_start === 1'b1)
      begin
         n_tx <= n_tx + 1;
         kind_log <= {kind_log[5:0], tx_kind};
      end
      if (activity_clear === 1'b1)
         n_clr <= n_clr + 1;
   end
   ////////////////////////////////////////////////////////////////////////
   task check(input [31:0] seen, input [31:0] exp, input [8*12-1:0] what);
   begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("mismatch %0s expected %h seen %h", what, exp, seen);
      end
   end
   endtask
   task wr(input [7:0] idx, input [7:0] d);
   begin
      host_bus_master_i.xfer(1'b1, idx * 4, {24'h0, d}, q);
   end
   endtask
   // Read and compare masked low byte; upper bits must read zero
   task rc(input [7:0] idx, input [7:0] m, input [7:0] e,
      input [8*12-1:0] what);
   begin
      host_bus_master_i.xfer(1'b0, idx * 4, 32'h0, q);
      check(q & {24'hffffff, m}, {24'h0, e}, what);
   end
   endtask
   // Poll the event flags, bounded
   task poll_evt(input [7:0] e);
      integer n;
   begin
      n = 0;
      q = 32'h0;
      while (q[7:0] !== e && n < 500)
      begin
         host_bus_master_i.xfer(1'b0, `IDX_EVENTS * 4, 32'h0, q);
         n = n + 1;
      end
      check(q, {24'h0, e}, "event flags");
   end
   endtask
   // Field-on run with no outside field; dly is the expected delay
   task field_case(input [7:0] code, input [7:0] slots, input integer dly);
      integer cnt;
   begin
      wr(`IDX_OPERATION_CONTROL, 8'h80);
      wr(`IDX_EVENTS, 8'h03);
      wr(`IDX_AUXILIARY_DEFINITION, slots);
      wr(`IDX_COMMAND, code);
      cnt = 0;
      while (field_on !== 1'b1 && cnt < 2000)
      begin
         @(posedge ref_clk);
         #1;
         cnt = cnt + 1;
      end
      check(cnt >= dly - 1 && cnt <= dly + 4, 1, "field delay");
      @(posedge ref_clk);
      rc(`IDX_EVENTS, 8'hff, 8'h00, "guard wait");
      rc(`IDX_OPERATION_CONTROL, 8'hff, 8'h88, "tx enable");
      poll_evt(8'h01);
      $display("field-on test %h done", code);
   end
   endtask
   task stop_test;
   begin
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Watchdog well beyond the expected run of a few hundred cycles
   initial
   begin
      repeat (30000)
         @(posedge ref_clk);
      errors = errors + 1;
      stop_test;
   end
   initial
   begin
      errors = 0;
      n_tests = 0;
      n_tx = 0;
      n_clr = 0;
      kind_log = 8'h00;
      rstn = 1'b0;
      ext_field_pin = 1'b0;
      osc_freq_ok_pin = 1'b1;
      osc_ampl_ok_pin = 1'b1;
      rate_detect_display = 8'h00;
      repeat (6)
         @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      rc(`IDX_OPERATION_CONTROL, 8'hff, 8'h00, "opctl reset");
      rc(`IDX_MODE_DEFINITION, 8'hff, 8'h08, "mode reset");
      wr(8'hff, 8'hff);
      rc(8'hff, 8'hff, 8'h00, "unmapped");
      $display("reset test done");
      // Transmit refused while the transmitter is off
      wr(`IDX_OPERATION_CONTROL, 8'h80);
      wr(`IDX_COMMAND, `CMD_TX_REQUEST_A);
      rc(`IDX_EVENTS, 8'hff, 8'h00, "no event");
      check(n_tx, 0, "tx refused");
      // Host clears first, then all four kinds back to back
      wr(`IDX_OPERATION_CONTROL, 8'h88);
      wr(`IDX_COMMAND, `CMD_CLEAR);
      wr(`IDX_COMMAND, `CMD_TX_WITH_CHECKSUM);
      wr(`IDX_COMMAND, `CMD_TX_WITHOUT_CHECKSUM);
      wr(`IDX_COMMAND, `CMD_TX_REQUEST_A);
      wr(`IDX_COMMAND, `CMD_TX_WAKEUP_A);
      rc(`IDX_EVENTS, 8'hff, 8'h00, "tx no event");
      check(n_tx, 4, "tx count");
      check(kind_log, 8'h1b, "tx kinds");
      check(n_clr, 1, "clear pulse");
      $display("transmit test done");
      // Outside field: collision flag, field stays off, then clear
      wr(`IDX_OPERATION_CONTROL, 8'h80);
      ext_field_pin <= 1'b1;
      wr(`IDX_AUXILIARY_DEFINITION, 8'hc0);
      wr(`IDX_COMMAND, `CMD_RESPONSE_FIELD_ON);
      poll_evt(8'h02);
      check(field_on, 0, "field off");
      ext_field_pin <= 1'b0;
      wr(`IDX_COMMAND, `CMD_CLEAR);
      rc(`IDX_EVENTS, 8'hff, 8'h00, "clear events");
      $display("collision test done");
      // Each field-on variant run once with no outside field
      field_case(`CMD_INITIAL_FIELD_ON, 8'h40, 28);
      field_case(`CMD_RESPONSE_FIELD_ON, 8'hc0, 34);
      field_case(`CMD_RESPONSE_FIELD_ON_N0, 8'hc0, 10);
      // Field-on refused with oscillator amplitude not settled
      osc_ampl_ok_pin <= 1'b0;
      wr(`IDX_OPERATION_CONTROL, 8'h80);
      wr(`IDX_EVENTS, 8'h03);
      wr(`IDX_COMMAND, `CMD_INITIAL_FIELD_ON);
      repeat (60)
         @(posedge ref_clk);
      rc(`IDX_EVENTS, 8'hff, 8'h00, "refused evt");
      rc(`IDX_OPERATION_CONTROL, 8'hff, 8'h80, "refused opc");
      osc_ampl_ok_pin <= 1'b1;
      $display("refusal test done");
      // Leave rate detection for normal mode
      wr(`IDX_MODE_DEFINITION, 8'h80);
      rate_detect_display <= 8'h02;
      wr(`IDX_COMMAND, `CMD_GO_NORMAL_MODE);
      rc(`IDX_BIT_RATE_DEFINITION, 8'hff, 8'h02, "bit rate");
      rc(`IDX_AUXILIARY_DEFINITION, 8'h20, 8'h20, "mod type");
      rc(`IDX_MODE_DEFINITION, 8'hff, 8'h88, "normal mode");
      rate_detect_display <= 8'h05;
      wr(`IDX_COMMAND, `CMD_GO_NORMAL_MODE);
      rc(`IDX_BIT_RATE_DEFINITION, 8'hff, 8'h02, "no re-copy");
      $display("normal mode test done");
      // Analog preset in active initiator mode, then in type A
      wr(`IDX_MODE_DEFINITION, 8'h18);
      wr(`IDX_OPERATION_CONTROL, 8'h88);
      wr(`IDX_COMMAND, `CMD_ANALOG_PRESET);
      rc(`IDX_OPERATION_CONTROL, 8'hff, 8'ha0, "preset opc");
      rc(`IDX_TYPE_A_106K_SETTINGS, 8'h20, 8'h20, "start byte");
      rc(`IDX_RECEIVER_CONFIG_3, 8'h03, 8'h03, "rx cfg3");
      rc(`IDX_RECEIVER_CONFIG_1, 8'h80, 8'h00, "rx cfg1");
      wr(`IDX_MODE_DEFINITION, 8'h08);
      wr(`IDX_BIT_RATE_DEFINITION, 8'h00);
      wr(`IDX_OPERATION_CONTROL, 8'h88);
      wr(`IDX_COMMAND, `CMD_ANALOG_PRESET);
      rc(`IDX_TYPE_A_106K_SETTINGS, 8'h20, 8'h00, "a start");
      rc(`IDX_RECEIVER_CONFIG_1, 8'h80, 8'h80, "a rx cfg1");
      rc(`IDX_OPERATION_CONTROL, 8'hff, 8'h88, "a opc");
      $display("preset test done");
      stop_test;
   end
endmodule
